// file: dv/jtag_debug_scan_port_sva.sv
// pin-level assertions for the test access port
`timescale 1ns/100ps
`include "jtag_port_params.svh"
module jtag_debug_scan_port_sva #(
  parameter int BSR_LEN = 16
) (
  input wire logic                       clk,
  input wire logic                       reset,
  input wire jtag_port_pkg::probe_pins_s probe,
  input wire logic                       tdo,
  input wire logic                       tdo_en,
  input wire logic [BSR_LEN-1:0]         pin_out,
  input wire logic                       extest_mode,
  input wire jtag_port_pkg::mem_req_s    mem_req,
  input wire logic [`DBG_W-1:0]          debug_ctrl,
  input wire logic                       bist_start,
  input wire logic                       manufacturing_scan_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------------
  // tck edges reach the core two or three clocks late, hence the $past depth
  // ----------------------------------------------------------------------
  a_reset_vals: assert property ($fell(reset) |-> !tdo_en && !mem_req.valid && !bist_start
    && debug_ctrl == '0 && pin_out == '0 && !extest_mode && !manufacturing_scan_enable)
    else $error("outputs not idle after reset");
  a_tdo_on_fall: assert property (tdo_en && $changed(tdo) |-> !$past(probe.tck, 2))
    else $error("tdo moved after a rising tck");
  a_en_on_fall: assert property ($changed(tdo_en) |-> !$past(probe.tck, 2))
    else $error("tdo enable moved after a rising tck");
  a_en_holds: assert property ($rose(tdo_en) |=> tdo_en [*5])
    else $error("tdo enable dropped inside a shift");
  a_req_pulse: assert property (mem_req.valid |-> $past(probe.tck, 2) ##1 !mem_req.valid)
    else $error("memory request not a single pulse on update");
  a_bist_pulse: assert property (bist_start |-> $past(probe.tck, 2) ##1 !bist_start)
    else $error("self test start not a single pulse");
  a_modes_excl: assert property (!(extest_mode && manufacturing_scan_enable))
    else $error("two instruction modes at once");
  a_mode_at_update: assert property ($changed(extest_mode) ||
    $changed(manufacturing_scan_enable) |-> $past(probe.tck, 2))
    else $error("mode changed away from an update");
  a_dbg_on_rise: assert property ($changed(debug_ctrl) |-> $past(probe.tck, 2))
    else $error("debug control changed away from an update");
  a_pins_on_rise: assert property ($changed(pin_out) |-> $past(probe.tck, 2))
    else $error("boundary outputs changed away from an update");
endmodule

bind jtag_debug_scan_port jtag_debug_scan_port_sva #(.BSR_LEN(BSR_LEN)) sva_inst (
  .clk(clk), .reset(reset), .probe(probe), .tdo(tdo), .tdo_en(tdo_en),
  .pin_out(pin_out), .extest_mode(extest_mode), .mem_req(mem_req),
  .debug_ctrl(debug_ctrl), .bist_start(bist_start),
  .manufacturing_scan_enable(manufacturing_scan_enable)
);

// file: dv/jtag_debug_scan_port_tb.sv
// self-checking bench for the test access port
`timescale 1ns/100ps
`include "jtag_port_params.svh"
module jtag_debug_scan_port_tb;
  logic                       clk = 1'b0;
  logic                       reset = 1'b1;
  jtag_port_pkg::probe_pins_s probe;
  logic                       tdo, tdo_en, extest_mode, bist_start, mfg_en;
  logic [15:0]                pin_in = '0, pin_out, bist_result = '0;
  logic [31:0]                mem_rdata = '0, cpu_pc = '0;
  logic [4:0]                 ctx = '0;
  logic [14:0]                debug_ctrl;
  jtag_port_pkg::mem_req_s    mem_req, last_req;
  logic [63:0]                dout;
  int                         err_total = 0, n_tests = 0, n_valid = 0, n_bist = 0, cycles = 0;
  localparam logic [7:0]      codes [13] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'hfe,
                                             8'hf8, 8'hfa, 8'hff, 8'h07, 8'h0f, 8'h5a, 8'h00};
  localparam int              lens [13] = '{37, 32, 32, 37, 15, 32, 16, 16, 1, 16, 1, 1, 1};
  localparam logic [63:0]     pat = 64'h9e37_79b9_7f4a_7c15;

  initial forever #20 clk = ~clk;

  jtag_debug_scan_port jtag_debug_scan_port_inst (
    .clk(clk), .reset(reset), .probe(probe), .tdo(tdo), .tdo_en(tdo_en),
    .pin_in(pin_in), .pin_out(pin_out), .extest_mode(extest_mode), .mem_req(mem_req),
    .mem_rdata(mem_rdata), .cpu_pc(cpu_pc), .active_context(ctx),
    .debug_ctrl(debug_ctrl), .bist_start(bist_start), .bist_result(bist_result),
    .manufacturing_scan_enable(mfg_en)
  );
  jtag_probe_model jtag_probe_model_inst (
    .clk(clk), .pins(probe), .tdo(tdo), .tdo_en(tdo_en)
  );

  // ----------------------------------------------------------------------
  // pulse counters and hang guard; a pulse is one clock, so count every edge
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (mem_req.valid === 1'b1) begin
      n_valid++;
      last_req = mem_req;
    end
    if (bist_start === 1'b1) n_bist++;
    if (cycles == 40000) begin
      err_total++;
      results();
    end
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic load(input logic [7:0] code);
    jtag_probe_model_inst.scan(1, 8, {56'h0, code}, dout);
    chk("ir capture", 8'h01, dout[7:0]);
  endtask

  task automatic dr(input int n, input logic [63:0] din);
    jtag_probe_model_inst.scan(0, n, din, dout);
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_idcode();
    jtag_probe_model_inst.tms_reset();
    dr(32, 64'h0);
    chk("idcode", `IDCODE_DEF, dout[31:0]);
  endtask

  // overshift 64 bits: the pattern reappears after exactly the chain length
  task automatic t_lengths();
    for (int k = 0; k < 13; k++) begin
      load(codes[k]);
      dr(64, pat);
      chk($sformatf("chain %h", codes[k]), pat << lens[k],
          dout & ({64{1'b1}} << lens[k]));
    end
  endtask

  task automatic t_private();
    int v0;
    v0 = n_valid;
    load(8'h12);
    dr(32, 64'hcafe_f00d);
    load(8'h10);
    dr(37, {27'h0, 4'h5, 1'b1, 32'h0000_1234});
    chk("request count", v0 + 1, n_valid);
    chk("request addr", 32'h0000_1234, last_req.addr);
    chk("request ctl", 5'h15, {last_req.write, last_req.be});
    chk("request data", 32'hcafe_f00d, last_req.wdata);
    dr(37, 64'h0);
    chk("command readback", {4'h5, 1'b1, 32'h0000_1234}, dout[36:0]);
    @(negedge clk);
    mem_rdata = 32'h8bad_beef;
    cpu_pc = 32'h0040_0abc;
    ctx = 5'h13;
    load(8'h11);
    dr(32, 64'h0);
    chk("read data", 32'h8bad_beef, dout[31:0]);
    load(8'h13);
    dr(37, 64'h0);
    chk("pc context", {5'h13, 32'h0040_0abc}, dout[36:0]);
    load(8'h14);
    dr(15, 64'h5a3c);
    chk("debug ctrl", 15'h5a3c, debug_ctrl);
    dr(15, 64'h0);
    chk("debug readback", 15'h5a3c, dout[14:0]);
  endtask

  task automatic t_boundary();
    @(negedge clk);
    pin_in = 16'hc3a5;
    load(8'hf8);
    dr(16, 64'h1e2d);
    chk("pins sampled", 16'hc3a5, dout[15:0]);
    chk("pins driven", 16'h1e2d, pin_out);
    chk("extest mode", 1'b1, extest_mode);
    @(negedge clk);
    pin_in = 16'h0ff0;
    load(8'hfa);
    chk("extest mode", 1'b0, extest_mode);
    dr(16, 64'h7001);
    chk("pins sampled", 16'h0ff0, dout[15:0]);
    chk("pins preloaded", 16'h7001, pin_out);
  endtask

  task automatic t_bist();
    int b0;
    @(negedge clk);
    bist_result = 16'h6d2b;
    b0 = n_bist;
    load(8'h07);
    chk("self test start", b0 + 1, n_bist);
    dr(16, 64'h0);
    chk("self test result", 16'h6d2b, dout[15:0]);
    chk("no restart", b0 + 1, n_bist);
    load(8'h0f);
    dr(8, 64'h0);
    chk("scan test mode", 1'b1, mfg_en);
    jtag_probe_model_inst.tms_reset();
    chk("scan test mode", 1'b0, mfg_en);
    dr(32, 64'h0);
    chk("idcode after tms reset", `IDCODE_DEF, dout[31:0]);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    t_idcode();
    t_lengths();
    t_private();
    t_boundary();
    t_bist();
    chk("tdo enable faults", 0, jtag_probe_model_inst.en_bad);
    results();
  end
endmodule

// file: dv/jtag_probe_model.sv
// external probe: drives tck, tms and tdi, samples tdo
`timescale 1ns/100ps
module jtag_probe_model (
  input  wire logic                  clk,
  output jtag_port_pkg::probe_pins_s pins,
  input  wire logic                  tdo,
  input  wire logic                  tdo_en
);
  int en_bad = 0;
  initial pins = 3'b011;

  // ----------------------------------------------------------------------
  // one tck period: 4 clocks low, 4 high; tck rests low between frames
  // ----------------------------------------------------------------------
  task automatic tick(input logic m, input logic d, input logic sh, output logic o);
    @(negedge clk);
    pins.tms <= m;
    pins.tdi <= d;
    repeat (3) @(negedge clk);
    o = tdo;
    if (tdo_en !== sh) en_bad++;
    pins.tck <= 1'b1;
    repeat (4) @(negedge clk);
    pins.tck <= 1'b0;
  endtask

  // idle -> capture -> shift n bits -> update -> idle
  task automatic scan(input logic ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout);
    logic x;
    dout = '0;
    tick(1, 0, 0, x);
    if (ir) tick(1, 0, 0, x);
    tick(0, 0, 0, x);
    tick(0, 0, 0, x);
    for (int i = 0; i < n; i++) tick(i == n - 1, din[i], 1, dout[i]);
    tick(1, 0, 0, x);
    tick(0, 0, 0, x);
  endtask

  task automatic tms_reset();
    logic x;
    repeat (5) tick(1, 0, 0, x);
    tick(0, 0, 0, x);
  endtask
endmodule

// file: shared/jtag_port_params.svh
// constants for the test access port: codes, chain lengths, field positions
`ifndef JTAG_PORT_PARAMS_SVH
`define JTAG_PORT_PARAMS_SVH

// ----------------------------------------------------------------------
// instruction register
// ----------------------------------------------------------------------
`define IR_W            8
`define IR_CAPTURE      8'h01
`define CODE_MEM_CMD    8'h10
`define CODE_MEM_RD     8'h11
`define CODE_MEM_WR     8'h12
`define CODE_PC_CTX     8'h13
`define CODE_DBG_CTRL   8'h14
`define CODE_IDCODE     8'hfe
`define CODE_EXTEST     8'hf8
`define CODE_SAMPLE     8'hfa
`define CODE_BYPASS     8'hff
`define CODE_BIST       8'h07
`define CODE_ATPG       8'h0f

// ----------------------------------------------------------------------
// chain lengths
// ----------------------------------------------------------------------
`define LEN_MEM_CMD     37
`define LEN_MEM_DATA    32
`define LEN_PC_CTX      37
`define LEN_DBG_CTRL    15
`define LEN_IDCODE      32
`define LEN_BIST        16
`define LEN_BYPASS      1
`define BSR_LEN_DEF     16
`define DR_MIN_W        37

// ----------------------------------------------------------------------
// field layouts of the private chains
// ----------------------------------------------------------------------
`define ADDR_W          32
`define DATA_W          32
`define BE_W            4
`define CTX_W           5
`define DBG_W           15
`define BIST_W          16
`define MEM_WRITE_BIT   32
`define MEM_BE_LSB      33
`define DBG_RESET       15'h0000
`define IDCODE_DEF      32'h0a5a5001

`endif

// file: shared/jtag_port_pkg.sv
// types shared by the test access port design
package jtag_port_pkg;

`include "jtag_port_params.svh"

  // --------------------------------------------------------------------
  // controller states
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    tap_exit2_dr    = 4'b0000,
    tap_exit1_dr    = 4'b0001,
    tap_shift_dr    = 4'b0010,
    tap_pause_dr    = 4'b0011,
    tap_select_ir   = 4'b0100,
    tap_update_dr   = 4'b0101,
    tap_capture_dr  = 4'b0110,
    tap_select_dr   = 4'b0111,
    tap_exit2_ir    = 4'b1000,
    tap_exit1_ir    = 4'b1001,
    tap_shift_ir    = 4'b1010,
    tap_pause_ir    = 4'b1011,
    tap_idle        = 4'b1100,
    tap_update_ir   = 4'b1101,
    tap_capture_ir  = 4'b1110,
    tap_reset       = 4'b1111
  } tap_state_e;

  // --------------------------------------------------------------------
  // decoded instruction
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    op_mem_cmd  = 4'b0000,
    op_mem_rd   = 4'b0001,
    op_mem_wr   = 4'b0010,
    op_pc_ctx   = 4'b0011,
    op_dbg_ctrl = 4'b0100,
    op_idcode   = 4'b0101,
    op_extest   = 4'b0110,
    op_sample   = 4'b0111,
    op_bypass   = 4'b1000,
    op_bist     = 4'b1001,
    op_atpg     = 4'b1010
  } op_e;

  // serial probe pins, as sampled
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } probe_pins_s;

  // request toward the core memory/register access path
  typedef struct packed {
    logic                valid;
    logic                write;
    logic [`BE_W-1:0]    be;
    logic [`ADDR_W-1:0]  addr;
    logic [`DATA_W-1:0]  wdata;
  } mem_req_s;

endpackage

// file: verilog/bit_sync.sv
// two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/100ps
module bit_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_s;

  sync_s state;
  sync_s next_state;

  always_comb begin
    next_state.meta   = async_in;
    next_state.stable = state.meta;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.stable;

endmodule

// file: verilog/jtag_debug_scan_port.sv
// test access port with instruction decode and debug scan chains
//
// Functional notes
// RL1: standard tap controller with instruction, bypass and boundary registers.
// RL2: tdo is released except in shift-dr and shift-ir.
// RL3: tdo changes only on falling edges of tck while shifting.
// RL4: tms and tdi are sampled on rising tck; the probe keeps them stable.
// RL5: instruction register is eight bits wide.
// RL6: instruction shifted in shift-ir, takes effect only at update-ir.
// RL7: last decoded instruction stays active until another is decoded.
// RL8: instructions and data enter least significant bit first.
// RL9: code 10h selects the 37-bit address and command chain.
// RL10: code 11h selects the 32-bit read data chain.
// RL11: code 12h selects the 32-bit write data chain.
// RL12: code 13h selects the 37-bit program counter and context chain.
// RL13: code 14h selects the 15-bit debug control chain, read and write.
// RL14: code feh selects the 32-bit identification register.
// RL15: code f8h selects the boundary chain in external test mode.
// RL16: code fah samples pins at capture-dr and preloads at update-dr.
// RL17: code ffh places the 1-bit bypass register between tdi and tdo.
// RL18: code 07h starts self test and selects the 16-bit result chain.
// RL19: code 0fh enables manufacturing scan mode, no chain of its own.
// RL20: every unassigned instruction code behaves as bypass.
// RL21: power-on reset or test-logic-reset selects the identification instruction.
// RL22: private chain layouts and side effects are defined here.
`timescale 1ns/100ps
`include "jtag_port_params.svh"
module jtag_debug_scan_port #(
  parameter int          BSR_LEN      = `BSR_LEN_DEF,
  parameter logic [31:0] IDCODE_VALUE = `IDCODE_DEF  // arbitrary value, bit 0 set
) (
  input  wire logic                         clk,
  input  wire logic                         reset,
  input  wire jtag_port_pkg::probe_pins_s   probe,
  output logic                              tdo,
  output logic                              tdo_en,
  input  wire logic [BSR_LEN-1:0]           pin_in,
  output logic      [BSR_LEN-1:0]           pin_out,
  output logic                              extest_mode,
  output jtag_port_pkg::mem_req_s           mem_req,
  input  wire logic [`DATA_W-1:0]           mem_rdata,
  input  wire logic [`ADDR_W-1:0]           cpu_pc,
  input  wire logic [`CTX_W-1:0]            active_context,
  output logic      [`DBG_W-1:0]            debug_ctrl,
  output logic                              bist_start,
  input  wire logic [`BIST_W-1:0]           bist_result,
  output logic                              manufacturing_scan_enable
);

  localparam int DRW = (BSR_LEN > `DR_MIN_W) ? BSR_LEN : `DR_MIN_W;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    jtag_port_pkg::tap_state_e  tap;
    logic [`IR_W-1:0]           ir_shift;
    logic [`IR_W-1:0]           ir;
    logic [DRW-1:0]             dr;
    logic                       tck_prev;
    logic                       tdo;
    logic                       tdo_en;
    jtag_port_pkg::mem_req_s    req;
    logic [`DBG_W-1:0]          dbg;
    logic [BSR_LEN-1:0]         bsr_hold;
    logic                       bist_start;
    logic                       extest;
    logic                       scan_mfg;
  } port_s;

  port_s state;
  port_s next_state;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  jtag_port_pkg::probe_pins_s probe_sync;
  logic [BSR_LEN-1:0]         pin_sync;

  bit_sync #(
    .W        ($bits(jtag_port_pkg::probe_pins_s))
  ) u_probe_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in (probe),
    .sync_out (probe_sync)
  );

  bit_sync #(
    .W        (BSR_LEN)
  ) u_pin_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic jtag_port_pkg::op_e decode(input logic [`IR_W-1:0] code);
    unique case (code)
      `CODE_MEM_CMD:  decode = jtag_port_pkg::op_mem_cmd;   // RL9
      `CODE_MEM_RD:   decode = jtag_port_pkg::op_mem_rd;    // RL10
      `CODE_MEM_WR:   decode = jtag_port_pkg::op_mem_wr;    // RL11
      `CODE_PC_CTX:   decode = jtag_port_pkg::op_pc_ctx;    // RL12
      `CODE_DBG_CTRL: decode = jtag_port_pkg::op_dbg_ctrl;  // RL13
      `CODE_IDCODE:   decode = jtag_port_pkg::op_idcode;    // RL14
      `CODE_EXTEST:   decode = jtag_port_pkg::op_extest;    // RL15
      `CODE_SAMPLE:   decode = jtag_port_pkg::op_sample;    // RL16
      `CODE_BIST:     decode = jtag_port_pkg::op_bist;      // RL18
      `CODE_ATPG:     decode = jtag_port_pkg::op_atpg;      // RL19
      default:        decode = jtag_port_pkg::op_bypass;    // RL17 RL20
    endcase
  endfunction

  function automatic int chain_len(input jtag_port_pkg::op_e op);
    unique case (op)
      jtag_port_pkg::op_mem_cmd:  chain_len = `LEN_MEM_CMD;
      jtag_port_pkg::op_mem_rd:   chain_len = `LEN_MEM_DATA;
      jtag_port_pkg::op_mem_wr:   chain_len = `LEN_MEM_DATA;
      jtag_port_pkg::op_pc_ctx:   chain_len = `LEN_PC_CTX;
      jtag_port_pkg::op_dbg_ctrl: chain_len = `LEN_DBG_CTRL;
      jtag_port_pkg::op_idcode:   chain_len = `LEN_IDCODE;
      jtag_port_pkg::op_extest:   chain_len = BSR_LEN;
      jtag_port_pkg::op_sample:   chain_len = BSR_LEN;
      jtag_port_pkg::op_bist:     chain_len = `LEN_BIST;
      // no chain of its own: bypass keeps tdi-to-tdo defined
      default:                    chain_len = `LEN_BYPASS;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // tap controller
  // ----------------------------------------------------------------------
  function automatic jtag_port_pkg::tap_state_e tap_next(
    input jtag_port_pkg::tap_state_e s,
    input logic                      tms
  );
    unique case (s)
      jtag_port_pkg::tap_reset:
        tap_next = tms ? jtag_port_pkg::tap_reset      : jtag_port_pkg::tap_idle;

      jtag_port_pkg::tap_idle:
        tap_next = tms ? jtag_port_pkg::tap_select_dr  : jtag_port_pkg::tap_idle;

      jtag_port_pkg::tap_select_dr:
        tap_next = tms ? jtag_port_pkg::tap_select_ir  : jtag_port_pkg::tap_capture_dr;

      jtag_port_pkg::tap_capture_dr:
        tap_next = tms ? jtag_port_pkg::tap_exit1_dr   : jtag_port_pkg::tap_shift_dr;

      jtag_port_pkg::tap_shift_dr:
        tap_next = tms ? jtag_port_pkg::tap_exit1_dr   : jtag_port_pkg::tap_shift_dr;

      jtag_port_pkg::tap_exit1_dr:
        tap_next = tms ? jtag_port_pkg::tap_update_dr  : jtag_port_pkg::tap_pause_dr;

      jtag_port_pkg::tap_pause_dr:
        tap_next = tms ? jtag_port_pkg::tap_exit2_dr   : jtag_port_pkg::tap_pause_dr;

      jtag_port_pkg::tap_exit2_dr:
        tap_next = tms ? jtag_port_pkg::tap_update_dr  : jtag_port_pkg::tap_shift_dr;

      jtag_port_pkg::tap_update_dr:
        tap_next = tms ? jtag_port_pkg::tap_select_dr  : jtag_port_pkg::tap_idle;

      jtag_port_pkg::tap_select_ir:
        tap_next = tms ? jtag_port_pkg::tap_reset      : jtag_port_pkg::tap_capture_ir;

      jtag_port_pkg::tap_capture_ir:
        tap_next = tms ? jtag_port_pkg::tap_exit1_ir   : jtag_port_pkg::tap_shift_ir;

      jtag_port_pkg::tap_shift_ir:
        tap_next = tms ? jtag_port_pkg::tap_exit1_ir   : jtag_port_pkg::tap_shift_ir;

      jtag_port_pkg::tap_exit1_ir:
        tap_next = tms ? jtag_port_pkg::tap_update_ir  : jtag_port_pkg::tap_pause_ir;

      jtag_port_pkg::tap_pause_ir:
        tap_next = tms ? jtag_port_pkg::tap_exit2_ir   : jtag_port_pkg::tap_pause_ir;

      jtag_port_pkg::tap_exit2_ir:
        tap_next = tms ? jtag_port_pkg::tap_update_ir  : jtag_port_pkg::tap_shift_ir;

      jtag_port_pkg::tap_update_ir:
        tap_next = tms ? jtag_port_pkg::tap_select_dr  : jtag_port_pkg::tap_idle;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  jtag_port_pkg::op_e op;
  logic               tck_rise;
  logic               tck_fall;
  int                 len;

  assign op       = decode(state.ir);
  // tck_prev resets low like the idle pin, so reset brings no false edge
  assign tck_rise = probe_sync.tck & ~state.tck_prev;  // RL4
  assign tck_fall = ~probe_sync.tck & state.tck_prev;  // RL3

  always_comb begin
    next_state            = state;
    next_state.tck_prev   = probe_sync.tck;
    next_state.req.valid  = 1'b0;
    next_state.bist_start = 1'b0;
    len                   = chain_len(op);

    if (tck_rise) begin
      next_state.tap = tap_next(state.tap, probe_sync.tms);  // RL1 RL4
      unique case (state.tap)
        jtag_port_pkg::tap_reset: begin
          next_state.ir = `CODE_IDCODE;  // RL21
        end

        jtag_port_pkg::tap_capture_ir: begin
          next_state.ir_shift = `IR_CAPTURE;
        end

        jtag_port_pkg::tap_shift_ir: begin
          // lsb leaves first, new bit enters at the top
          next_state.ir_shift = {probe_sync.tdi, state.ir_shift[`IR_W-1:1]};  // RL5 RL8
        end

        jtag_port_pkg::tap_update_ir: begin
          next_state.ir = state.ir_shift;  // RL6 RL7
          if (decode(state.ir_shift) == jtag_port_pkg::op_bist) begin
            next_state.bist_start = 1'b1;  // RL18
          end
        end

        jtag_port_pkg::tap_capture_dr: begin
          unique case (op)
            jtag_port_pkg::op_mem_cmd:
              next_state.dr = DRW'({state.req.be, state.req.write, state.req.addr});  // RL9 RL22

            jtag_port_pkg::op_mem_rd:
              next_state.dr = DRW'(mem_rdata);  // RL10

            jtag_port_pkg::op_mem_wr:
              next_state.dr = DRW'(state.req.wdata);  // RL11

            jtag_port_pkg::op_pc_ctx:
              next_state.dr = DRW'({active_context, cpu_pc});  // RL12

            jtag_port_pkg::op_dbg_ctrl:
              next_state.dr = DRW'(state.dbg);  // RL13

            jtag_port_pkg::op_idcode:
              next_state.dr = DRW'(IDCODE_VALUE);  // RL14

            jtag_port_pkg::op_extest,
            jtag_port_pkg::op_sample:
              next_state.dr = DRW'(pin_sync);  // RL15 RL16

            jtag_port_pkg::op_bist:
              next_state.dr = DRW'(bist_result);  // RL18

            default:
              next_state.dr = '0;  // RL17 RL20
          endcase
        end

        jtag_port_pkg::tap_shift_dr: begin
          // only bit len-1 takes tdi, so one register serves every chain
          next_state.dr          = state.dr >> 1;  // RL8
          next_state.dr[len - 1] = probe_sync.tdi;
        end

        jtag_port_pkg::tap_update_dr: begin
          unique case (op)
            jtag_port_pkg::op_mem_cmd: begin
              // each update issues one access toward the core
              next_state.req.addr  = state.dr[`ADDR_W-1:0];  // RL9 RL22
              next_state.req.write = state.dr[`MEM_WRITE_BIT];
              next_state.req.be    = state.dr[`MEM_BE_LSB +: `BE_W];
              next_state.req.valid = 1'b1;
            end

            jtag_port_pkg::op_mem_wr: begin
              next_state.req.wdata = state.dr[`DATA_W-1:0];  // RL11
            end

            jtag_port_pkg::op_dbg_ctrl: begin
              next_state.dbg = state.dr[`DBG_W-1:0];  // RL13
            end

            jtag_port_pkg::op_extest,
            jtag_port_pkg::op_sample: begin
              next_state.bsr_hold = state.dr[BSR_LEN-1:0];  // RL15 RL16
            end

            default: begin
            end
          endcase
        end

        default: begin
        end
      endcase
    end

    if (tck_fall) begin
      // output and its enable move together, on the falling edge only
      next_state.tdo_en = (state.tap == jtag_port_pkg::tap_shift_dr) ||
                          (state.tap == jtag_port_pkg::tap_shift_ir);  // RL2 RL3
      next_state.tdo    = (state.tap == jtag_port_pkg::tap_shift_ir) ?
                          state.ir_shift[0] : state.dr[0];  // RL3
    end

    // mode pins come from flops that load in the same clock as the instruction
    next_state.extest   = (decode(next_state.ir) == jtag_port_pkg::op_extest);  // RL15
    next_state.scan_mfg = (decode(next_state.ir) == jtag_port_pkg::op_atpg);    // RL19
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      // the '0 default also clears both mode flags, as the identification code needs
      state          <= '0;
      state.tap      <= jtag_port_pkg::tap_reset;
      state.ir       <= `CODE_IDCODE;  // RL21
      state.ir_shift <= `IR_CAPTURE;
      state.dbg      <= `DBG_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign tdo                       = state.tdo;
  assign tdo_en                    = state.tdo_en;  // RL2
  assign pin_out                   = state.bsr_hold;
  assign extest_mode               = state.extest;  // RL15
  assign mem_req                   = state.req;
  assign debug_ctrl                = state.dbg;
  assign bist_start                = state.bist_start;
  assign manufacturing_scan_enable = state.scan_mfg;  // RL19

endmodule
